// ### spi_port_pkg.sv
// Constants, field positions and carrier types for the byte-wide serial port.
// Assumes a single core clock domain plus the link clock taken from the pin.

package spi_port_pkg;

    // ==========================================================
    // Sizes and timing
    localparam int BYTE_BITS = 8;
    localparam logic [3:0] LAST_EDGE = 4'hF; // Sixteen clock edges make one byte
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [15:0] HALF_PERIOD_BASE = 16'h0002; // Fastest rate is core clock / 4

    // ==========================================================
    // Control register fields
    localparam int CR_IRQ_EN = 7;
    localparam int CR_OUT_EN = 6;
    localparam int CR_RATE2 = 5;
    localparam int CR_MASTER = 4;
    localparam int CR_IDLE = 3;
    localparam int CR_PHASE = 2;
    localparam int CR_RATE1 = 1;
    localparam int CR_RATE0 = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // ==========================================================
    // Control/status register fields
    localparam int SR_DONE = 7;
    localparam int SR_WRITE_COLLISION_FLAG = 6;
    localparam int SR_OVR = 5;
    localparam int SR_MASTER_FAULT_FLAG = 4;
    localparam int SR_SSM = 1;
    localparam int SR_SSI = 0;
    localparam logic SSM_RESET = 1'b0;
    localparam logic SSI_RESET = 1'b0;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic cr_wr;
        logic csr_wr;
        logic csr_rd;
        logic dr_wr;
        logic dr_rd;
        logic [7:0] wdata;
    } cpu_access_t;

    typedef enum logic {M_IDLE, M_SHIFT} master_state_t;

endpackage

// ### sync_2ff.sv
// Two-stage synchroniser for a group of independent levels.
// Assumes each bit is a level or a toggle; no word is carried through it.
`timescale 1ns/100ps

module sync_2ff #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk, // Destination clock
    input wire logic srst, // Synchronous reset, active high
    input wire logic ce, // Clock enable
    input wire logic [WIDTH-1:0] async_in, // Levels from another domain
    output logic [WIDTH-1:0] sync_out // Safe copies
);

    logic [WIDTH-1:0] meta;

    // ==========================================================
    // First stage is read only by the second
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            meta <= '0;
            sync_out <= '0;
        end
        else if (ce)
        begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule

// ### spi_master_slave_port.sv
// Byte-wide serial port, master or slave, with its control/status flags.
// Assumes CPU access strobes are one-cycle pulses on core_clk and that the
// link clock only runs while the internal select is low in slave mode.
//
// Operation
// - Soft select mode takes level from bit
// - First-edge slave select toggles between bytes
// - Master and enable stay only while select high in master mode
// - Master data write starts MSB-first shifting
// - Byte end sets done flag, interrupt
// - Master clears done: status access, data read
// - Data writes ignored while done, unread status
// - Slave data write shifts out on clock
// - Slave clears done: status access, data access
// - Clock idle level and edges match
// - Low select in master sets mode fault
// - Fault clears: status read, control write
// - Fault blocks enable and master set
// - Byte over pending done sets overrun
// - Status read clears overrun
// - Busy data write discarded, collision flag
// - Phase bit picks first or second edge
`timescale 1ns/100ps

module spi_master_slave_port (
    input wire logic core_clk, // Core clock, 25 MHz
    input wire logic srst, // Synchronous reset, active high
    input wire logic ce, // Clock enable, freezes core state when low
    input wire spi_port_pkg::cpu_access_t cpu, // CPU register strobes and data
    input wire logic cpu_int_mask, // CPU interrupt mask, set blocks requests
    output logic [7:0] control, // Control register contents
    output logic [7:0] status, // Control/status register contents
    output logic [7:0] rx_data, // Receive buffer, the data register read
    output logic irq, // Interrupt request
    input wire logic sck_link, // Serial clock pin, input side
    input wire logic ss_n_pin, // Slave select pin, active low
    input wire logic mosi_in, // Master-out pin, input side
    input wire logic miso_in, // Master-in pin, input side
    output logic sck_out, // Serial clock pin, output side
    output logic sck_oe, // Serial clock pin enable
    output logic mosi_out, // Master-out pin, output side
    output logic mosi_oe, // Master-out pin enable
    output logic miso_out, // Master-in pin, output side
    output logic miso_oe // Master-in pin enable
);

    // ==========================================================
    // Declarations
    logic [7:0] ctrl;
    logic soft_select_mode;
    logic soft_select_level;
    logic transfer_done_flag;
    logic write_collision_flag;
    logic overrun_flag;
    logic master_fault_flag;
    logic done_armed;
    logic done_status_read;
    logic write_collision_flag_armed;
    logic fault_armed;
    logic [7:0] tx_byte;
    logic [7:0] shreg;
    spi_port_pkg::master_state_t mstate;
    logic [15:0] div_cnt;
    logic [3:0] edge_cnt;
    logic sck_q;
    logic mosi_q;
    logic tgl_seen;
    logic [3:0] sync_q;
    logic ss_n_s;
    logic miso_s;
    logic link_busy_s;
    logic done_tgl_s;
    // Link domain
    logic [2:0] bit_cnt;
    logic [2:0] out_idx;
    logic [7:0] rx_sh;
    logic [7:0] rx_hold;
    logic link_busy;
    logic done_tgl;
    // Decodes
    logic master_on;
    logic port_on;
    logic clock_idle_level;
    logic clock_phase_sel;
    logic sel_high;
    logic sel_high_raw;
    logic slave_on;
    logic fault;
    logic tick;
    logic byte_done_m;
    logic slave_evt;
    logic byte_done;
    logic busy;
    logic dr_inhibit;
    logic dr_accept;
    logic done_clear;
    logic overrun_now;
    logic [7:0] master_rx;
    logic link_rst;
    logic sample_clk;

    // ==========================================================
    // Helpers

    // Half period of the master clock in core cycles
    function automatic logic [15:0] half_period(input logic [2:0] rate);
        half_period = 16'(spi_port_pkg::HALF_PERIOD_BASE << rate);
    endfunction

    // ==========================================================
    // Synchronised pin and link levels
    sync_2ff #(
        .WIDTH(4)
    ) u_sync (
        .core_clk(core_clk),
        .srst(srst),
        .ce(ce),
        .async_in({ss_n_pin, miso_in, link_busy, done_tgl}),
        .sync_out(sync_q)
    );

    assign ss_n_s = sync_q[3];
    assign miso_s = sync_q[2];
    assign link_busy_s = sync_q[1];
    assign done_tgl_s = sync_q[0];

    // ==========================================================
    // Decodes
    assign master_on = ctrl[spi_port_pkg::CR_MASTER];
    assign port_on = ctrl[spi_port_pkg::CR_OUT_EN];
    assign clock_idle_level = ctrl[spi_port_pkg::CR_IDLE];
    assign clock_phase_sel = ctrl[spi_port_pkg::CR_PHASE];
    // Soft mode frees the pin and uses the software level
    assign sel_high = soft_select_mode ? soft_select_level : ss_n_s;
    assign slave_on = port_on & ~master_on;
    // A master that sees its select low has a rival on the bus
    assign fault = master_on & ~sel_high;
    assign tick = (mstate == spi_port_pkg::M_SHIFT) &&
        (div_cnt == 16'(half_period({ctrl[spi_port_pkg::CR_RATE2],
        ctrl[spi_port_pkg::CR_RATE1:spi_port_pkg::CR_RATE0]}) - 16'h0001));
    assign byte_done_m = tick && (edge_cnt == spi_port_pkg::LAST_EDGE);
    assign slave_evt = (done_tgl_s ^ tgl_seen) & slave_on;
    assign byte_done = byte_done_m | slave_evt;
    // First-edge slave counts as busy for the whole select-low time
    assign busy = (mstate == spi_port_pkg::M_SHIFT) | (slave_on &
        ((~sel_high & ~clock_phase_sel) | link_busy_s));
    assign dr_inhibit = transfer_done_flag & ~done_status_read;
    assign dr_accept = cpu.dr_wr & ~dr_inhibit & ~busy;
    // Slave may finish the sequence with a write as well as a read
    assign done_clear = done_armed & (cpu.dr_rd | (~master_on & cpu.dr_wr));
    assign overrun_now = byte_done & transfer_done_flag & ~done_clear;
    // Second-edge capture lands the last bit in the done cycle itself
    assign master_rx = clock_phase_sel ? {shreg[6:0], miso_s} : shreg;

    // ==========================================================
    // Control register
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            ctrl <= spi_port_pkg::CTRL_RESET;
        end
        else if (ce)
        begin
            if (fault)
            begin
                ctrl[spi_port_pkg::CR_OUT_EN] <= 1'b0;
                ctrl[spi_port_pkg::CR_MASTER] <= 1'b0;
            end
            else if (cpu.cr_wr)
            begin
                ctrl <= cpu.wdata;
                // Outside the clearing write the fault keeps both bits from rising
                if (master_fault_flag && !fault_armed)
                begin
                    ctrl[spi_port_pkg::CR_OUT_EN] <= cpu.wdata[spi_port_pkg::CR_OUT_EN] &
                        ctrl[spi_port_pkg::CR_OUT_EN];
                    ctrl[spi_port_pkg::CR_MASTER] <= cpu.wdata[spi_port_pkg::CR_MASTER] &
                        ctrl[spi_port_pkg::CR_MASTER];
                end
            end
        end
    end

    // ==========================================================
    // Select management bits of the control/status register
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            soft_select_mode <= spi_port_pkg::SSM_RESET;
            soft_select_level <= spi_port_pkg::SSI_RESET;
        end
        else if (ce && cpu.csr_wr)
        begin
            soft_select_mode <= cpu.wdata[spi_port_pkg::SR_SSM];
            soft_select_level <= cpu.wdata[spi_port_pkg::SR_SSI];
        end
    end

    // ==========================================================
    // Transfer done flag and its two-step clear; a new byte wins
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            transfer_done_flag <= 1'b0;
            done_armed <= 1'b0;
            done_status_read <= 1'b0;
        end
        else if (ce)
        begin
            if (byte_done)
                transfer_done_flag <= 1'b1;
            else if (done_clear)
                transfer_done_flag <= 1'b0;
            if (!transfer_done_flag || done_clear)
                done_armed <= 1'b0;
            else if (cpu.csr_rd || cpu.csr_wr)
                done_armed <= 1'b1;
            if (!transfer_done_flag || done_clear)
                done_status_read <= 1'b0;
            else if (cpu.csr_rd)
                done_status_read <= 1'b1;
        end
    end

    // ==========================================================
    // Overrun flag: cleared by a status read, a new overrun wins
    always_ff @(posedge core_clk)
    begin
        if (srst)
            overrun_flag <= 1'b0;
        else if (ce)
        begin
            if (overrun_now)
                overrun_flag <= 1'b1;
            else if (cpu.csr_rd)
                overrun_flag <= 1'b0;
        end
    end

    // ==========================================================
    // Write collision flag: status read, then a data access clears
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            write_collision_flag <= 1'b0;
            write_collision_flag_armed <= 1'b0;
        end
        else if (ce)
        begin
            if (cpu.dr_wr && busy && !dr_inhibit)
                write_collision_flag <= 1'b1;
            else if (write_collision_flag_armed && (cpu.dr_rd || cpu.dr_wr))
                write_collision_flag <= 1'b0;
            if (!write_collision_flag || cpu.dr_rd || cpu.dr_wr)
                write_collision_flag_armed <= 1'b0;
            else if (cpu.csr_rd)
                write_collision_flag_armed <= 1'b1;
        end
    end

    // ==========================================================
    // Mode fault flag: status read, then a control write clears
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            master_fault_flag <= 1'b0;
            fault_armed <= 1'b0;
        end
        else if (ce)
        begin
            if (fault)
                master_fault_flag <= 1'b1;
            else if (fault_armed && cpu.cr_wr)
                master_fault_flag <= 1'b0;
            if (!master_fault_flag || cpu.cr_wr)
                fault_armed <= 1'b0;
            else if (cpu.csr_rd)
                fault_armed <= 1'b1;
        end
    end

    // ==========================================================
    // Receive buffer keeps the first byte after the last clear
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            rx_data <= 8'h00;
            tgl_seen <= 1'b0;
        end
        else if (ce)
        begin
            tgl_seen <= done_tgl_s;
            if (byte_done && !overrun_now)
                rx_data <= byte_done_m ? master_rx : rx_hold;
        end
    end

    // ==========================================================
    // Slave transmit byte, held still while the link shifts it
    always_ff @(posedge core_clk)
    begin
        if (srst)
            tx_byte <= 8'h00;
        else if (ce && dr_accept && !master_on)
            tx_byte <= cpu.wdata;
    end

    // ==========================================================
    // Master engine: divider, sixteen edges, capture and drive
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            mstate <= spi_port_pkg::M_IDLE;
            div_cnt <= 16'h0000;
            edge_cnt <= 4'h0;
            shreg <= 8'h00;
            sck_q <= 1'b0;
            mosi_q <= 1'b0;
        end
        else if (ce)
        begin
            unique case (mstate)
                spi_port_pkg::M_IDLE:
                begin
                    sck_q <= clock_idle_level;
                    if (dr_accept && master_on && port_on && sel_high)
                    begin
                        shreg <= cpu.wdata;
                        mosi_q <= cpu.wdata[7];
                        div_cnt <= 16'h0000;
                        edge_cnt <= 4'h0;
                        mstate <= spi_port_pkg::M_SHIFT;
                    end
                end
                spi_port_pkg::M_SHIFT:
                begin
                    if (fault)
                    begin
                        // A rival master owns the bus now: drop the byte
                        mstate <= spi_port_pkg::M_IDLE;
                        sck_q <= clock_idle_level;
                    end
                    else if (tick)
                    begin
                        div_cnt <= 16'h0000;
                        sck_q <= ~sck_q;
                        edge_cnt <= edge_cnt + 4'h1;
                        if (edge_cnt[0] == clock_phase_sel)
                            shreg <= {shreg[6:0], miso_s};
                        else
                            mosi_q <= shreg[7];
                        if (edge_cnt == spi_port_pkg::LAST_EDGE)
                            mstate <= spi_port_pkg::M_IDLE;
                    end
                    else
                        div_cnt <= div_cnt + 16'h0001;
                end
            endcase
        end
    end

    // ==========================================================
    // Pin enables and interrupt request, all registered
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            sck_oe <= 1'b0;
            mosi_oe <= 1'b0;
            miso_oe <= 1'b0;
            irq <= 1'b0;
        end
        else if (ce)
        begin
            sck_oe <= port_on & master_on & ~fault;
            mosi_oe <= port_on & master_on & ~fault;
            miso_oe <= slave_on & ~sel_high;
            // Collision is status only and raises nothing
            irq <= ctrl[spi_port_pkg::CR_IRQ_EN] & ~cpu_int_mask &
                (transfer_done_flag | overrun_flag | master_fault_flag);
        end
    end

    assign control = ctrl;
    assign status = {transfer_done_flag, write_collision_flag, overrun_flag,
        master_fault_flag, 2'b00, soft_select_mode, soft_select_level};
    assign sck_out = sck_q;
    assign mosi_out = mosi_q;

    // ==========================================================
    // Slave link logic on the master's clock
    // Frame reset comes straight from the select; the soft level is
    // a quiet register, so no glitch reaches the reset net in soft mode.
    assign sel_high_raw = soft_select_mode ? soft_select_level : ss_n_pin;
    assign link_rst = sel_high_raw | ~slave_on;
    // Capture edge: rising for modes 0 and 3, falling for modes 1 and 2
    assign sample_clk = sck_link ^ (clock_idle_level ^ clock_phase_sel);

    // Capture side: shift in and count bits
    always_ff @(posedge sample_clk or posedge link_rst)
    begin
        if (link_rst)
        begin
            bit_cnt <= 3'h0;
            rx_sh <= 8'h00;
            link_busy <= 1'b0;
        end
        else
        begin
            rx_sh <= {rx_sh[6:0], mosi_in};
            bit_cnt <= bit_cnt + 3'h1;
            link_busy <= (bit_cnt != spi_port_pkg::LAST_BIT);
        end
    end

    // Completed byte and its event toggle survive the frame reset
    always_ff @(posedge sample_clk or posedge srst)
    begin
        if (srst)
        begin
            rx_hold <= 8'h00;
            done_tgl <= 1'b0;
        end
        else if (bit_cnt == spi_port_pkg::LAST_BIT)
        begin
            rx_hold <= {rx_sh[6:0], mosi_in};
            done_tgl <= ~done_tgl;
        end
    end

    // Drive side: next bit index follows the capture count
    always_ff @(negedge sample_clk or posedge link_rst)
    begin
        if (link_rst)
            out_idx <= 3'h0;
        else
            out_idx <= bit_cnt;
    end

    // MSB is on the pin as soon as the frame opens, before any edge
    assign miso_out = tx_byte[~out_idx];

endmodule

// ### spi_port_checker.sv
// Concurrent checks on the serial port's CPU-side outputs.
// Assumes it is bound to every port instance; ce low pauses the checks.
`timescale 1ns/100ps

module spi_port_checker (
    input wire logic core_clk, // Core clock
    input wire logic srst, // Sync reset
    input wire logic ce, // Clock enable
    input wire spi_port_pkg::cpu_access_t cpu, // CPU strobes
    input wire logic cpu_int_mask, // Interrupt mask
    input wire logic [7:0] control, // Control register
    input wire logic [7:0] status, // Flags
    input wire logic irq // Interrupt request
);
    // ==========================================
    // Helpers
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst || !ce);
    logic fault_read;

    // Status read seen since the fault flag rose
    always_ff @(posedge core_clk)
    begin
        if (srst || !status[4])
            fault_read <= 1'b0;
        else if (cpu.csr_rd)
            fault_read <= 1'b1;
    end

    sequence done_clear_s;
        status[7] && (cpu.csr_rd || cpu.csr_wr) ##2 cpu.dr_rd;
    endsequence
    sequence fault_clear_s;
        status[4] && cpu.csr_rd ##2 cpu.cr_wr;
    endsequence

    // ==========================================
    // Assertions
    done_clear_a: assert property (done_clear_s |=> !status[7])
        else $error("done flag kept");
    fault_clear_a: assert property (fault_clear_s |=> !status[4])
        else $error("fault flag kept");
    ovr_clear_a: assert property (status[5] && cpu.csr_rd |=> !status[5])
        else $error("overrun kept");
    fault_drop_a: assert property ($rose(status[4]) |-> !control[6] && !control[4])
        else $error("fault left enables set");
    slave_nofault_a: assert property (!control[4] && !cpu.cr_wr && !status[4] |=> !status[4])
        else $error("fault in slave mode");
    fault_block_a: assert property (status[4] && !fault_read && cpu.cr_wr && !cpu.csr_rd
        |=> !control[6] && !control[4])
        else $error("enable set under fault");
    irq_gate_a: assert property ((!control[7] || cpu_int_mask) |=> !irq)
        else $error("irq while gated");
    irq_cause_a: assert property (irq |-> $past(status[7] || status[5] || status[4]))
        else $error("irq without cause");
    irq_raise_a: assert property ($rose(status[7]) && control[7] && !cpu_int_mask |=> irq)
        else $error("irq missing");
endmodule

bind spi_master_slave_port spi_port_checker spi_port_checker_inst (.core_clk, .srst, .ce,
    .cpu, .cpu_int_mask, .control, .status, .irq);

// ### spi_far_end.sv
// Far side: a slave for the port as master, a master for it as slave.
// Assumes mode 0 on the wire; the link clock stands still between bytes.
`timescale 1ns/100ps

module spi_far_end (
    input wire logic sck_out, // Port clock as master
    input wire logic mosi_out, // Port data as master
    input wire logic miso_out, // Port data as slave
    output logic miso_in, // Reply to port master
    output logic sck_link, // Clock to port slave
    output logic mosi_in, // Data to port slave
    output logic ss_n // Select to port slave
);
    logic [7:0] reply = 8'h3C;
    logic [7:0] got = 8'h00;
    initial sck_link = 1'b0;
    initial mosi_in = 1'b0;
    initial ss_n = 1'b1;

    // Capture on the first edge, shift on the second; vacated bits invert
    assign miso_in = reply[7];
    always @(posedge sck_out) got <= {got[6:0], mosi_out};
    always @(negedge sck_out) reply <= {reply[6:0], ~reply[7]};

    // Reload before a frame; idle-level writes clock stray edges
    task automatic arm(input logic [7:0] b);
        reply = b;
    endtask

    // One byte as master; select high again between bytes
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        ss_n = 1'b0;
        #40;
        for (int i = 7; i >= 0; i--)
        begin
            mosi_in = tx[i];
            #40 sck_link = 1'b1;
            rx = {rx[6:0], miso_out};
            #40 sck_link = 1'b0;
        end
        #40 ss_n = 1'b1;
        mosi_in = ~mosi_in;
    endtask
endmodule

// ### spi_master_slave_port_bench.sv
// Self-checking bench: reset, master, fault and slave runs of the port.
// Assumes the far-side model and the bound checker beside it.
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end

module spi_master_slave_port_bench;
    localparam logic [4:0] CR = 5'h10, CSW = 5'h08, CSR = 5'h04, DW = 5'h02, DR = 5'h01;
    logic core_clk = 0, srst = 0, ce = 1, cpu_int_mask = 0, pin_low = 0;
    spi_port_pkg::cpu_access_t cpu = '0;
    logic [7:0] control, status, rx_data, r;
    logic irq, sck_link, ss_n, mosi_in, miso_in, sck_out, sck_oe;
    logic mosi_out, mosi_oe, miso_out, miso_oe;
    int bad_count = 0, n_tests = 0;
    wire logic ss_n_pin = ss_n & ~pin_low; // Bench pulls select for faults

    spi_master_slave_port spi_master_slave_port_inst (.core_clk, .srst, .ce, .cpu,
        .cpu_int_mask, .control, .status, .rx_data, .irq, .sck_link, .ss_n_pin, .mosi_in,
        .miso_in, .sck_out, .sck_oe, .mosi_out, .mosi_oe, .miso_out, .miso_oe);
    spi_far_end spi_far_end_inst (.sck_out, .mosi_out, .miso_out, .miso_in, .sck_link,
        .mosi_in, .ss_n);

    // ==========================================
    // Clock and helpers
    initial forever #20 core_clk = ~core_clk;

    // One-cycle strobe; a gap cycle follows
    task automatic op(input logic [4:0] k, input logic [7:0] d);
        @(negedge core_clk);
        cpu = {k, d};
        @(negedge core_clk);
        cpu = '0;
    endtask

    task automatic wait_done;
        int n = 0;
        while (status[7] !== 1'b1 && n < 300)
        begin
            @(negedge core_clk);
            n++;
        end
        `CHK(status[7], 1'b1)
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset;
        `CHK(control, spi_port_pkg::CTRL_RESET)
        `CHK({irq, status, rx_data}, 17'h00000)
        $display("test reset done");
    endtask

    task automatic t_master;
        op(CR, 8'h09);
        @(negedge core_clk);
        `CHK(sck_out, 1'b1)
        op(CR, 8'h01);
        op(CSW, 8'h03);
        op(CR, 8'hD1);
        @(negedge core_clk);
        `CHK(control, 8'hD1)
        spi_far_end_inst.arm(8'h3C);
        op(DW, 8'hA5);
        op(DW, 8'h0F);
        wait_done();
        @(negedge core_clk);
        `CHK(spi_far_end_inst.got, 8'hA5)
        `CHK(rx_data, 8'h3C)
        `CHK({irq, status[6]}, 2'b11)
        op(DW, 8'h77);
        repeat (10) @(negedge core_clk);
        `CHK(sck_out, 1'b0)
        op(CSR, 8'h00);
        op(DR, 8'h00);
        @(negedge core_clk);
        `CHK(status[7:6], 2'b00)
        $display("test master done");
    endtask

    task automatic t_fault;
        op(CSW, 8'h00);
        pin_low = 1'b1;
        repeat (6) @(negedge core_clk);
        `CHK({status[4], irq, control[6], control[4]}, 4'hC)
        op(CR, 8'hD1);
        @(negedge core_clk);
        `CHK(control[4], 1'b0)
        pin_low = 1'b0;
        repeat (4) @(negedge core_clk);
        op(CSR, 8'h00);
        op(CR, 8'hD1);
        @(negedge core_clk);
        `CHK({status[4], control}, 9'h0D1)
        op(CSW, 8'h03);
        pin_low = 1'b1;
        repeat (6) @(negedge core_clk);
        `CHK({status[4], control[4]}, 2'b01)
        pin_low = 1'b0;
        $display("test fault done");
    endtask

    task automatic t_slave;
        op(CSW, 8'h00);
        op(CR, 8'hC0);
        op(DW, 8'h96);
        #13;
        spi_far_end_inst.xfer(8'h5A, r);
        `CHK(r, 8'h96)
        wait_done();
        `CHK(rx_data, 8'h5A)
        spi_far_end_inst.xfer(8'hC3, r);
        repeat (8) @(negedge core_clk);
        `CHK({status[5], rx_data}, 9'h15A)
        op(CSR, 8'h00);
        op(DW, 8'h11);
        @(negedge core_clk);
        `CHK(status[7:5], 3'b000)
        $display("test slave done");
    endtask

    // ==========================================
    // Main sequence and watchdog
    initial
    begin
        // A real rising edge so the link-side flops clear as well
        #5 srst = 1'b1;
        repeat (10) @(negedge core_clk);
        srst = 1'b0;
        t_reset();
        t_master();
        t_fault();
        t_slave();
        end_sim();
    end

    initial
    begin
        #200us;
        bad_count++;
        end_sim();
    end
endmodule
